/* File: rtl/mps_pkg.sv */
// Package of constants for the multiphase startup sequencer
package mps_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned NUM_PHASES = 4;
   // Phase output encoding
   localparam logic [1:0] PH_MID = 2'h0;
   localparam logic [1:0] PH_LOW = 2'h1;
   localparam logic [1:0] PH_HIGH = 2'h2;
   // Boot refresh burst lengths in PWM clock cycles
   localparam int unsigned START_REFRESH_CYC = 8;
   localparam int unsigned DROP_REFRESH_CYC = 4;
   // Periodic refresh interval
   localparam int unsigned REFRESH_PERIOD_US = 500;
   localparam int unsigned REFRESH_PERIOD_CYC = REFRESH_PERIOD_US * (CLK_HZ / 1_000_000);
   // Soft-on duration
   localparam int unsigned SOFTON_MS = 100;
   localparam int unsigned SOFTON_CYC = SOFTON_MS * (CLK_HZ / 1000);
   // Duty resolution for soft-on and phase drop ramps
   localparam int unsigned DUTY_W = 8;
   localparam logic [7:0] DUTY_FULL = 8'hff;
   localparam logic [7:0] DUTY_ZERO = 8'h00;
   typedef enum logic [2:0] {
      MPS_OFF, MPS_PREBIAS, MPS_REFRESH, MPS_WAIT_COMP, MPS_SOFTSTART,
      MPS_SOFTON, MPS_DROP, MPS_STEADY
   } mps_state_e;
endpackage

/* File: rtl/mps_sequencer.sv */
// Startup and phase-drop sequencer for a multiphase PWM controller
// Summary of operation
// R1: Run request low keeps driver enable low and all phase outputs mid-level.
// R2: Run request rising starts the soft-start period.
// R3: Soft-start node pre-biased to feedback first, ramp released after.
// R4: Driver enable goes high right after pre-bias completes.
// R5: Startup boot refresh drives every phase low for eight cycles.
// R6: No switching until error amp output exceeds ramp offset.
// R7: Soft-start complete flags when soft-start node reaches clamp.
// R8: During soft-start switching is non-synchronous, sync FETs off.
// R9: Soft-on raises sync FET on-time gradually, up to 100 ms.
// R10: Selected phase dropping ramps dropped phases' duty down to off.
// R11: Active phase count holds while load current is unchanged.
// R12: Dropped phases refreshed every 500 us, low for four cycles.
// R14: Analog crossings arrive as bits; phase outputs are three-state codes.
module mps_sequencer
   import mps_pkg::*;
#(
   parameter int unsigned NPH = NUM_PHASES,
   parameter int unsigned SOFTON_CYCLES = SOFTON_CYC,
   parameter int unsigned REFRESH_CYCLES = REFRESH_PERIOD_CYC
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic run_req_i,
   input wire logic prebias_done_i,
   input wire logic comp_above_offset_i,
   input wire logic ss_at_clamp_i,
   input wire logic drop_enable_i,
   input wire logic light_load_i,
   input wire logic [NPH-1:0] drop_mask_i,
   input wire logic [NPH-1:0] pwm_high_i,
   output logic gate_driver_enable_out_o,
   output logic [2*NPH-1:0] phase_drive_out_o,
   output logic sync_fet_enable_o,
   output logic [DUTY_W-1:0] sync_duty_o,
   output logic [DUTY_W-1:0] drop_duty_o,
   output logic [NPH-1:0] dropped_o,
   output logic softstart_done_o,
   output logic prebias_active_o,
   output logic ss_ramp_enable_o
);
   mps_state_e state_q;
   // One bit per analog crossing, independent of the phase count
   logic [3:0] sync_in_q1, sync_in_q2;
   logic run_q, prebias_q, comp_q, clamp_q;
   logic [3:0] burst_q;
   logic [31:0] timer_q;
   logic [31:0] refresh_q;
   logic [DUTY_W-1:0] sync_duty_q, drop_duty_q;
   logic [NPH-1:0] dropped_q;
   logic drop_refresh_q;
   logic [1:0] ph_code_q [NPH];

   // Two-stage synchronisers for analog crossings
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         sync_in_q1 <= '0;
         sync_in_q2 <= '0;
      end
      else
      begin
         sync_in_q1 <= {run_req_i, prebias_done_i, comp_above_offset_i, ss_at_clamp_i};
         sync_in_q2 <= sync_in_q1;
      end
   end
   assign run_q = sync_in_q2[3]; // [R14]
   assign prebias_q = sync_in_q2[2];
   assign comp_q = sync_in_q2[1];
   assign clamp_q = sync_in_q2[0];

   // Main sequence
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_q <= MPS_OFF;
         burst_q <= '0;
         timer_q <= '0;
      end
      else if (!run_q)
      begin
         state_q <= MPS_OFF; // [R1]
         burst_q <= '0;
         timer_q <= '0;
      end
      else
      begin
         case (state_q)
            MPS_OFF:
               state_q <= MPS_PREBIAS; // [R2]
            MPS_PREBIAS:
               if (prebias_q)
               begin
                  state_q <= MPS_REFRESH; // [R3] [R4]
                  burst_q <= 4'(START_REFRESH_CYC - 1);
               end
            MPS_REFRESH:
               if (burst_q == 4'h0)
                  state_q <= MPS_WAIT_COMP;
               else
                  burst_q <= burst_q - 4'h1; // [R5]
            MPS_WAIT_COMP:
               if (comp_q)
                  state_q <= MPS_SOFTSTART; // [R6]
            MPS_SOFTSTART:
               if (clamp_q)
               begin
                  state_q <= MPS_SOFTON; // [R7]
                  timer_q <= '0;
               end
            MPS_SOFTON:
               if (timer_q >= SOFTON_CYCLES - 1 || sync_duty_q == DUTY_FULL)
                  state_q <= MPS_DROP; // [R9]
               else
                  timer_q <= timer_q + 32'h1;
            MPS_DROP:
               if (!(drop_enable_i && light_load_i) || drop_duty_q == DUTY_ZERO)
                  state_q <= MPS_STEADY;
            MPS_STEADY:
               state_q <= MPS_STEADY; // [R11]
            default:
               state_q <= MPS_OFF;
         endcase
      end
   end

   // Soft-on ramp: one duty step per slice of the soft-on time
   localparam int unsigned DUTY_STEPS = 2 ** DUTY_W;
   localparam int unsigned STEP_CYC = (SOFTON_CYCLES / DUTY_STEPS > 0)
                                      ? SOFTON_CYCLES / DUTY_STEPS : 1;
   always_ff @(posedge clock_i)
   begin
      if (rst_i || state_q == MPS_OFF)
         sync_duty_q <= DUTY_ZERO;
      else if (state_q == MPS_SOFTON && (timer_q % STEP_CYC) == 0 && sync_duty_q != DUTY_FULL)
         sync_duty_q <= sync_duty_q + 8'h01; // [R9]
      else if (state_q == MPS_DROP || state_q == MPS_STEADY)
         sync_duty_q <= DUTY_FULL;
   end

   // Phase drop duty ramp and dropped set
   always_ff @(posedge clock_i)
   begin
      if (rst_i || state_q == MPS_OFF)
      begin
         drop_duty_q <= DUTY_FULL;
         dropped_q <= '0;
      end
      else if (state_q == MPS_DROP && drop_enable_i && light_load_i)
      begin
         if (drop_duty_q != DUTY_ZERO)
            drop_duty_q <= drop_duty_q - 8'h01; // [R10]
         else
            dropped_q <= drop_mask_i;
      end
   end

   // Periodic boot refresh of dropped phases
   always_ff @(posedge clock_i)
   begin
      if (rst_i || state_q != MPS_STEADY)
      begin
         refresh_q <= '0;
         drop_refresh_q <= 1'b0;
      end
      else if (refresh_q >= REFRESH_CYCLES - 1)
      begin
         refresh_q <= '0; // [R12]
         drop_refresh_q <= 1'b1;
      end
      else
      begin
         refresh_q <= refresh_q + 32'h1;
         if (refresh_q == 32'(DROP_REFRESH_CYC - 1))
            drop_refresh_q <= 1'b0; // [R12]
      end
   end

   // Per-phase output encoding
   genvar g;
   generate
      for (g = 0; g < NPH; g++)
      begin : g_phase
         always_ff @(posedge clock_i)
         begin
            if (rst_i)
               ph_code_q[g] <= PH_MID;
            else
            begin
               case (state_q)
                  MPS_REFRESH:
                     ph_code_q[g] <= PH_LOW; // [R5]
                  MPS_SOFTSTART:
                     ph_code_q[g] <= pwm_high_i[g] ? PH_HIGH : PH_MID; // [R8]
                  MPS_SOFTON, MPS_DROP:
                     ph_code_q[g] <= pwm_high_i[g] ? PH_HIGH : PH_LOW;
                  MPS_STEADY:
                     if (dropped_q[g])
                        ph_code_q[g] <= drop_refresh_q ? PH_LOW : PH_MID; // [R12]
                     else
                        ph_code_q[g] <= pwm_high_i[g] ? PH_HIGH : PH_LOW;
                  default:
                     ph_code_q[g] <= PH_MID; // [R1] [R6]
               endcase
            end
         end
         assign phase_drive_out_o[2*g +: 2] = ph_code_q[g]; // [R14]
      end
   endgenerate

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         gate_driver_enable_out_o <= 1'b0;
         softstart_done_o <= 1'b0;
      end
      else
      begin
         gate_driver_enable_out_o <= run_q && state_q != MPS_OFF && state_q != MPS_PREBIAS; // [R4]
         softstart_done_o <= run_q && (state_q == MPS_SOFTON || state_q == MPS_DROP
                             || state_q == MPS_STEADY); // [R7]
      end
   end

   assign prebias_active_o = (state_q == MPS_PREBIAS); // [R3]
   assign ss_ramp_enable_o = (state_q != MPS_OFF) && (state_q != MPS_PREBIAS);
   assign sync_fet_enable_o = (state_q == MPS_SOFTON) || (state_q == MPS_DROP)
                              || (state_q == MPS_STEADY); // [R8]
   assign sync_duty_o = sync_duty_q;
   assign drop_duty_o = drop_duty_q;
   assign dropped_o = dropped_q;

   a_off_holds_mid: assert property (@(posedge clock_i) disable iff (rst_i) // [R1]
      state_q == MPS_OFF |=> ph_code_q[0] == PH_MID && !gate_driver_enable_out_o)
      else $error("phase not mid while off");
   a_refresh_low_eight: assert property (@(posedge clock_i) disable iff (rst_i) // [R5]
      $rose(state_q == MPS_REFRESH) && run_q |-> (state_q == MPS_REFRESH)[*8])
      else $error("start refresh not eight cycles");
   a_wait_no_switch: assert property (@(posedge clock_i) disable iff (rst_i) // [R6]
      state_q == MPS_WAIT_COMP && !comp_q ##1 state_q == MPS_WAIT_COMP |-> ph_code_q[1] == PH_MID)
      else $error("switching before comp crossing");
   a_prebias_first: assert property (@(posedge clock_i) disable iff (rst_i) // [R3]
      state_q == MPS_PREBIAS |-> !ss_ramp_enable_o)
      else $error("ramp before prebias");
   a_drv_after_prebias: assert property (@(posedge clock_i) disable iff (rst_i) // [R4]
      state_q == MPS_PREBIAS && prebias_q && run_q |=> ##1 gate_driver_enable_out_o || !run_q)
      else $error("driver enable late");
   a_ss_nonsync: assert property (@(posedge clock_i) disable iff (rst_i) // [R8]
      state_q == MPS_SOFTSTART |-> !sync_fet_enable_o)
      else $error("sync fet during soft-start");
   a_done_on_clamp: assert property (@(posedge clock_i) disable iff (rst_i) // [R7]
      state_q == MPS_SOFTSTART && clamp_q && run_q |=> ##1 softstart_done_o || !run_q)
      else $error("soft-start done missing");
   a_steady_holds: assert property (@(posedge clock_i) disable iff (rst_i) // [R11]
      state_q == MPS_STEADY && run_q |=> $stable(dropped_q))
      else $error("phase count changed in steady");
   a_drop_ramps_down: assert property (@(posedge clock_i) disable iff (rst_i) // [R10]
      state_q == MPS_DROP && drop_enable_i && light_load_i && drop_duty_q != DUTY_ZERO
      && run_q |=> drop_duty_q == $past(drop_duty_q) - 8'h01)
      else $error("drop duty not stepping");
   a_run_starts: assert property (@(posedge clock_i) disable iff (rst_i) // [R2]
      state_q == MPS_OFF && run_q |=> state_q == MPS_PREBIAS)
      else $error("no start on run");
   c_reach_steady: cover property (@(posedge clock_i) state_q == MPS_STEADY);
   c_drop_refresh: cover property (@(posedge clock_i) drop_refresh_q && dropped_q != '0);
   c_abort_run: cover property (@(posedge clock_i) state_q == MPS_SOFTSTART ##1 state_q == MPS_OFF);
endmodule

/* File: verification/mps_power_stage_model.sv */
// Behavioural model of the external gate drivers and power stages
module mps_power_stage_model
   import mps_pkg::*;
#(
   parameter int unsigned NPH = NUM_PHASES,
   parameter int unsigned BOOT_HOLD = 100
)
(
   input wire logic clock_i,
   input wire logic gate_driver_enable_out_i,
   input wire logic [2*NPH-1:0] phase_i,
   output logic [NPH-1:0] boot_ok_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned age_q [NPH] = '{default: BOOT_HOLD};
   // Bootstrap charges only while the low-side FET conducts
   always @(posedge clock_i)
   begin
      for (int i = 0; i < NPH; i++)
      begin
         if (gate_driver_enable_out_i && phase_i[2*i +: 2] == PH_LOW)
            age_q[i] <= 0;
         else if (age_q[i] < BOOT_HOLD)
            age_q[i] <= age_q[i] + 1;
      end
   end
   always_comb
   begin
      for (int i = 0; i < NPH; i++)
         boot_ok_o[i] = age_q[i] < BOOT_HOLD;
   end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the multiphase startup sequencer
module testbench
   import mps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned RF = 64;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic run = 1'b0, pbd = 1'b0, comp = 1'b0, clamp = 1'b0, den = 1'b0, ll = 1'b0;
   logic [3:0] mask = 4'h0, pwmh = 4'h0, dropped, boot_ok;
   logic gate_driver_enable_out, sync_en, ss_done, pb_act, ramp_en;
   logic [7:0] ph, sduty, dduty;
   int err_total = 0, checks_done = 0, cyc = 0;

   mps_sequencer #(.NPH(4), .SOFTON_CYCLES(512), .REFRESH_CYCLES(RF)) u_mps_sequencer (
      .clock_i(clock_i), .rst_i(rst_i), .run_req_i(run), .prebias_done_i(pbd),
      .comp_above_offset_i(comp), .ss_at_clamp_i(clamp), .drop_enable_i(den),
      .light_load_i(ll), .drop_mask_i(mask), .pwm_high_i(pwmh),
      .gate_driver_enable_out_o(gate_driver_enable_out), .phase_drive_out_o(ph),
      .sync_fet_enable_o(sync_en), .sync_duty_o(sduty), .drop_duty_o(dduty),
      .dropped_o(dropped), .softstart_done_o(ss_done), .prebias_active_o(pb_act),
      .ss_ramp_enable_o(ramp_en));
   mps_power_stage_model #(.NPH(4)) u_mps_power_stage_model (
      .clock_i(clock_i), .gate_driver_enable_out_i(gate_driver_enable_out), .phase_i(ph), .boot_ok_o(boot_ok));

   initial
   begin
      forever #5 clock_i = ~clock_i;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic t_off(input int c);
      repeat (c) @(negedge clock_i)
      begin
         chk(gate_driver_enable_out === 1'b0 && ph === 8'h00, "drive while off");
      end
   endtask

   task automatic t_start();
      int n;
      @(posedge clock_i) run <= 1'b1;
      for (n = 0; n < 8 && pb_act !== 1'b1; n++) @(negedge clock_i);
      chk(pb_act === 1'b1, "no prebias");
      repeat (10) @(negedge clock_i)
      begin
         chk(ramp_en === 1'b0 && gate_driver_enable_out === 1'b0, "early ramp");
      end
      @(posedge clock_i) pbd <= 1'b1;
      for (n = 0; n < 6 && gate_driver_enable_out !== 1'b1; n++) @(negedge clock_i);
      chk(gate_driver_enable_out === 1'b1, "drivers off");
      for (n = 0; n < 4 && ph !== 8'h55; n++) @(negedge clock_i);
      for (n = 0; n < 20 && ph === 8'h55; n++) @(negedge clock_i);
      chk(n == 8 && boot_ok === 4'hf, "boot refresh");
      @(posedge clock_i) pwmh <= 4'hf;
      repeat (20) @(negedge clock_i)
      begin
         chk(ph === 8'h00, "switch before comp");
      end
      @(posedge clock_i) comp <= 1'b1;
      for (n = 0; n < 6 && ph !== 8'haa; n++) @(negedge clock_i);
      chk(ph === 8'haa, "no switching");
      repeat (16)
      begin
         @(posedge clock_i) pwmh <= ~pwmh;
         @(negedge clock_i);
         chk((ph & 8'h55) === 8'h00 && sync_en === 1'b0, "sync conduction");
         chk(ramp_en === 1'b1 && ss_done === 1'b0, "ramp state");
      end
      @(posedge clock_i) clamp <= 1'b1;
      for (n = 0; n < 6 && ss_done !== 1'b1; n++) @(negedge clock_i);
      chk(ss_done === 1'b1, "no ss done");
   endtask

   task automatic t_softon();
      int n;
      logic [7:0] prev;
      prev = sduty;
      for (n = 0; n < 700 && sduty !== DUTY_FULL; n++)
      begin
         @(negedge clock_i);
         chk(sduty >= prev, "soft-on duty fell");
         prev = sduty;
      end
      chk(sduty === DUTY_FULL && n > 8, "soft-on abrupt");
      chk(sync_en === 1'b1, "sync fet off after soft-start");
   endtask

   task automatic t_drop();
      int n;
      logic [7:0] prev;
      prev = DUTY_FULL;
      for (n = 0; n < 600 && dropped !== 4'h8; n++)
      begin
         @(negedge clock_i);
         chk(dduty <= prev, "drop duty rose");
         prev = dduty;
      end
      chk(dropped === 4'h8 && dduty === DUTY_ZERO && n > 8, "drop");
      for (n = 0; n < 2*RF && ph[7:6] !== PH_LOW; n++) @(negedge clock_i);
      repeat (3)
      begin
         for (n = 0; n < 20 && ph[7:6] === PH_LOW; n++) @(negedge clock_i);
         chk(n == 4, "refresh length");
         for (n = 4; n < 2*RF && ph[7:6] !== PH_LOW; n++)
         begin
            @(negedge clock_i);
            chk(dropped === 4'h8, "count changed");
         end
         chk(n == RF && boot_ok[3] === 1'b1, "refresh period");
      end
   endtask

   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         conclude();
      end
   end

   initial
   begin
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      den <= 1'b1;
      ll <= 1'b1;
      mask <= 4'h8;
      t_off(20);
      t_start();
      t_softon();
      t_drop();
      @(posedge clock_i) run <= 1'b0;
      repeat (5) @(negedge clock_i);
      t_off(10);
      conclude();
   end
endmodule
